// [core/tcmwac_decode.sv]
`timescale 1ns/10ps
// Address decode and access permission check for one coprocessor access
module tcmwac_decode
    import tcmwac_pkg::*;
(
    // Access fields
    input  wire logic [3:0] primary_reg_field_i,
    input  wire logic [3:0] secondary_reg_field_i,
    input  wire logic [2:0] opc1_i,
    input  wire logic [2:0] opc2_i,
    input  wire logic       write_i,
    input  wire logic       secure_i,
    input  wire logic       privileged_i,
    input  wire logic       secure_coproc_write_lock_i,
    // Results
    output logic            hit_data_o,
    output logic            hit_instr_o,
    output logic            undef_o
);
    logic base_hit;

    // Shared c9/c1/opcode1 match
    assign base_hit = (primary_reg_field_i == PRIMARY_C9) &&
                      (secondary_reg_field_i == SECONDARY_C1) &&
                      (opc1_i == OPC1_ZERO);
    // [RULE_10] data register decode
    assign hit_data_o  = base_hit && (opc2_i == OPC2_DATA);
    // [RULE_11] instruction register decode
    assign hit_instr_o = base_hit && (opc2_i == OPC2_INSTR);

    // Undefined on bad mode or locked write
    always_comb begin
        undef_o = 1'b0;
        if (hit_data_o || hit_instr_o) begin
            // [RULE_08] secure privileged only
            if (!(secure_i && privileged_i))
                undef_o = 1'b1;
            // [RULE_07] write lock trap
            else if (write_i && secure_coproc_write_lock_i)
                undef_o = 1'b1;
        end
    end
endmodule : tcmwac_decode

// [core/tcmwac_top.sv]
`timescale 1ns/10ps
// World access control for data and instruction tightly coupled memories
module tcmwac_top
    import tcmwac_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // Coprocessor register port
    input  wire logic        cp_valid_i,
    input  wire logic        cp_write_i,
    input  wire logic [3:0]  primary_reg_field_i,
    input  wire logic [3:0]  secondary_reg_field_i,
    input  wire logic [2:0]  opc1_i,
    input  wire logic [2:0]  opc2_i,
    input  wire logic [31:0] cp_wdata_i,
    input  wire logic        cp_secure_i,
    input  wire logic        cp_privileged_i,
    input  wire logic        secure_coproc_write_lock_i,
    input  wire logic [1:0]  memory_bank_select_i,
    output logic [31:0]      cp_rdata_o,
    output logic             cp_hit_o,
    output logic             cp_undef_o,
    // Memory access check, data side
    input  wire logic [1:0]  d_bank_i,
    input  wire logic        d_secure_i,
    input  wire logic        d_page_ns_i,
    output logic             d_visible_o,
    output logic             d_ns_data_o,
    output logic             d_region_ok_o,
    // Memory access check, instruction side
    input  wire logic [1:0]  i_bank_i,
    input  wire logic        i_secure_i,
    input  wire logic        i_page_ns_i,
    output logic             i_visible_o,
    output logic             i_ns_data_o,
    output logic             i_region_ok_o
);
    typedef struct packed {
        logic [NUM_BANKS-1:0] dvis;
        logic [NUM_BANKS-1:0] ivis;
        logic [31:0]          rdata;
        logic                 hit;
        logic                 undef;
    } tcmwac_state_type;

    tcmwac_state_type st_ff;
    tcmwac_state_type nxt_st;
    logic hit_d;
    logic hit_i;
    logic undef_c;
    logic bank_c;
    logic bank_ok;

    // Bank index valid only when that memory exists
    function automatic logic bank_exists(input logic [1:0] sel);
        bank_exists = (32'(sel) < NUM_BANKS);
    endfunction : bank_exists

    tcmwac_decode u_decode (
        .primary_reg_field_i        (primary_reg_field_i),
        .secondary_reg_field_i      (secondary_reg_field_i),
        .opc1_i                     (opc1_i),
        .opc2_i                     (opc2_i),
        .write_i                    (cp_write_i),
        .secure_i                   (cp_secure_i),
        .privileged_i               (cp_privileged_i),
        .secure_coproc_write_lock_i (secure_coproc_write_lock_i),
        .hit_data_o                 (hit_d),
        .hit_instr_o                (hit_i),
        .undef_o                    (undef_c)
    );

    // [RULE_13] selections of absent banks fall back to bank 0
    assign bank_ok = bank_exists(memory_bank_select_i);
    assign bank_c  = bank_ok ? memory_bank_select_i[0] : 1'b0;

    // Register update and read data, one cycle latency
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.hit   = cp_valid_i && (hit_d || hit_i);
        nxt_st.undef = cp_valid_i && undef_c;
        nxt_st.rdata = RDATA_RESET;
        if (cp_valid_i && (hit_d || hit_i) && !undef_c) begin
            if (cp_write_i) begin
                // [RULE_09] route write to selected bank
                // [RULE_14] upper write bits discarded
                if (hit_d)
                    nxt_st.dvis[bank_c] = cp_wdata_i[VIS_BIT_POS];
                else
                    nxt_st.ivis[bank_c] = cp_wdata_i[VIS_BIT_POS];
            end else begin
                // [RULE_01] only bit 0 carries state
                // [RULE_14] upper bits read zero
                nxt_st.rdata[VIS_BIT_POS] = hit_d ? st_ff.dvis[bank_c]
                                                  : st_ff.ivis[bank_c];
            end
        end
    end

    // State register; bits clear at reset
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            // [RULE_02] data bit resets to zero
            // [RULE_04] instruction bit resets to zero
            st_ff.dvis  <= {NUM_BANKS{VIS_RESET}};
            st_ff.ivis  <= {NUM_BANKS{VIS_RESET}};
            st_ff.rdata <= RDATA_RESET;
            st_ff.hit   <= 1'b0;
            st_ff.undef <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cp_rdata_o = st_ff.rdata;
    assign cp_hit_o   = st_ff.hit;
    assign cp_undef_o = st_ff.undef;

    // Per-side visibility, same logic for both sides
    logic d_bit;
    logic i_bit;
    assign d_bit = st_ff.dvis[bank_exists(d_bank_i) ? d_bank_i[0] : 1'b0];
    assign i_bit = st_ff.ivis[bank_exists(i_bank_i) ? i_bank_i[0] : 1'b0];

    tcmwac_visibility u_dvis (
        .vis_bit_i        (d_bit),
        .secure_i         (d_secure_i),
        .page_ns_attr_i   (d_page_ns_i),
        .visible_o        (d_visible_o),
        .ns_data_o        (d_ns_data_o),
        .region_ctrl_ok_o (d_region_ok_o)
    );

    // [RULE_04] instruction side identical encoding
    tcmwac_visibility u_ivis (
        .vis_bit_i        (i_bit),
        .secure_i         (i_secure_i),
        .page_ns_attr_i   (i_page_ns_i),
        .visible_o        (i_visible_o),
        .ns_data_o        (i_ns_data_o),
        .region_ctrl_ok_o (i_region_ok_o)
    );
endmodule : tcmwac_top

// [core/tcmwac_visibility.sv]
`timescale 1ns/10ps
// Visibility of one memory for one access, from bit and attribute
module tcmwac_visibility (
    // Inputs
    input  wire logic vis_bit_i,
    input  wire logic secure_i,
    input  wire logic page_ns_attr_i,
    // Outputs
    output logic      visible_o,
    output logic      ns_data_o,
    output logic      region_ctrl_ok_o
);
    // [RULE_05] secure needs bit equal attribute
    // [RULE_06] non-secure ignores attribute
    assign visible_o = secure_i ? (vis_bit_i == page_ns_attr_i) : vis_bit_i;
    // [RULE_02] contents secure when bit clear
    // [RULE_03] contents non-secure when bit set
    assign ns_data_o = vis_bit_i;
    // Region register reachable by non-secure only when bit set
    assign region_ctrl_ok_o = secure_i | vis_bit_i;
endmodule : tcmwac_visibility

// [pkg/tcmwac_pkg.sv]
// Operation
// [RULE_01] Bit 0 meaningful, bits 31:1 reserved
// [RULE_02] Bit 0 clear: secure only, attribute 0
// [RULE_03] Bit 1: both worlds, secure needs attribute 1
// [RULE_04] Instruction side same encoding, resets 0
// [RULE_05] Secure access visible when bit equals attribute
// [RULE_06] Non-secure ignores attribute, needs bit set
// [RULE_07] Locked secure write raises undefined, no update
// [RULE_08] Non-secure or user access raises undefined
// [RULE_09] Separate register per memory, bank routed
// [RULE_10] Data register at c9, c1, 0, 2
// [RULE_11] Instruction register at c9, c1, 0, 3
// [RULE_12] Software avoids region change during DMA
// [RULE_13] Two-bit bank select, missing banks ignored; the code routes them to bank 0 instead
// [RULE_14] Reads zero upper bits, writes discard them
package tcmwac_pkg;
    localparam int           NUM_BANKS     = 2;
    localparam logic [3:0]   PRIMARY_C9    = 4'h9;
    localparam logic [3:0]   SECONDARY_C1  = 4'h1;
    localparam logic [2:0]   OPC1_ZERO     = 3'h0;
    localparam logic [2:0]   OPC2_DATA     = 3'h2;
    localparam logic [2:0]   OPC2_INSTR    = 3'h3;
    localparam int           VIS_BIT_POS   = 0;
    localparam logic         VIS_RESET     = 1'b0;
    localparam logic [31:0]  RDATA_RESET   = 32'h0;
endpackage : tcmwac_pkg

// [test/tb_tcmwac_top.sv]
`timescale 1ns/10ps
`define chk(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); \
    end end
// Self-checking bench for the world access control block
module tb_tcmwac_top;
    logic        mclk_i = 1'b0, reset_i = 1'b1, lock = 1'b0;
    logic [1:0]  bank = 2'h0, i_bank = 2'h0;
    logic        d_sec = 1'b0, d_pns = 1'b0, i_sec = 1'b0, i_pns = 1'b0;
    logic        dro, ino, iro;
    logic        cv, cw, cs, cpv, hto, udo, dv, dn, iv, h, u;
    logic [2:0]  o2;
    logic [31:0] wd, rdo, rd;
    int          n_mismatch = 0, n_checks = 0;
    tcmwac_top tcmwac_top_inst (.mclk_i(mclk_i), .reset_i(reset_i),
        .cp_valid_i(cv), .cp_write_i(cw), .primary_reg_field_i(4'h9),
        .secondary_reg_field_i(4'h1), .opc1_i(3'h0), .opc2_i(o2),
        .cp_wdata_i(wd), .cp_secure_i(cs), .cp_privileged_i(cpv),
        .secure_coproc_write_lock_i(lock), .memory_bank_select_i(bank),
        .cp_rdata_o(rdo), .cp_hit_o(hto), .cp_undef_o(udo),
        .d_bank_i(2'h0), .d_secure_i(d_sec), .d_page_ns_i(d_pns),
        .d_visible_o(dv), .d_ns_data_o(dn), .d_region_ok_o(dro),
        .i_bank_i(i_bank), .i_secure_i(i_sec), .i_page_ns_i(i_pns),
        .i_visible_o(iv), .i_ns_data_o(ino), .i_region_ok_o(iro));
    tcmwac_core_model tcmwac_core_model_inst (.mclk_i(mclk_i),
        .cp_valid_o(cv), .cp_write_o(cw), .opc2_o(o2), .cp_wdata_o(wd),
        .cp_secure_o(cs), .cp_privileged_o(cpv), .cp_rdata_i(rdo),
        .cp_hit_i(hto), .cp_undef_i(udo));
    // 200 MHz clock
    initial forever #2.5 mclk_i = ~mclk_i;
    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // Access through the core model
    task automatic acc(input logic w, input logic [2:0] o2v,
        input logic [31:0] wdv);
        tcmwac_core_model_inst.access(w, o2v, wdv, 2'h3, rd, h, u);
    endtask : acc
    // Test sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        d_sec <= 1'b1;
        i_sec <= 1'b1;
        @(posedge mclk_i);
        #1;
        `chk("d_vis", 1'b1, dv)
        `chk("i_vis", 1'b1, iv)
        acc(1'b0, 3'h2, 32'h0);
        `chk("rd_reset", 32'h0, rd)
        // Every refused mode leaves the bit clear
        for (int m = 0; m < 3; m++) begin
            tcmwac_core_model_inst.access(1'b1, 3'h2, 32'h1, m[1:0], rd, h, u);
            `chk("undef", 1'b1, u)
            `chk("kept", 1'b0, dn)
        end
        acc(1'b1, 3'h2, 32'hffff_ffff);
        `chk("hit", 1'b1, h)
        acc(1'b0, 3'h2, 32'h0);
        `chk("rd_set", 32'h1, rd)
        // World and page attribute table with the bit set
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk_i);
            d_sec <= k[1];
            d_pns <= k[0];
            @(posedge mclk_i);
            #1;
            `chk("vis", k != 2, dv)
        end
        @(posedge mclk_i);
        lock <= 1'b1;
        acc(1'b1, 3'h2, 32'h0);
        `chk("lock", 1'b1, u)
        acc(1'b0, 3'h2, 32'h0);
        `chk("rd_lock", 32'h1, rd)
        // Bank 1 instruction side opened to the non-secure world
        @(posedge mclk_i);
        lock <= 1'b0;
        bank <= 2'h1;
        i_bank <= 2'h1;
        i_sec <= 1'b0;
        acc(1'b1, 3'h3, 32'h1);
        `chk("i_bank1", 1'b1, iv)
        `chk("i_ns_data", 1'b1, ino)
        `chk("i_region", 1'b1, iro)
        // Missing bank falls back to bank 0
        @(posedge mclk_i);
        bank <= 2'h2;
        acc(1'b1, 3'h2, 32'h0);
        `chk("bank_fb", 1'b0, dv)
        acc(1'b1, 3'h1, 32'h1);
        `chk("miss", 2'h0, {h, u})
        // Closed bit hides memory and region from the non-secure world
        @(posedge mclk_i);
        d_sec <= 1'b0;
        i_bank <= 2'h0;
        @(posedge mclk_i);
        #1;
        `chk("d_ns_vis", 1'b0, dv)
        `chk("d_region", 1'b0, dro)
        `chk("i_bank0", 1'b0, iv)
        `chk("i_region0", 1'b0, iro)
        // Secure instruction fetch with mismatched attribute is hidden
        @(posedge mclk_i);
        i_sec <= 1'b1;
        i_pns <= 1'b1;
        @(posedge mclk_i);
        #1;
        `chk("i_attr", 1'b0, iv)
        `chk("i_region_s", 1'b1, iro)
        end_sim();
    end
    // Watchdog well beyond the sequence length
    initial begin
        #5us;
        n_mismatch++;
        end_sim();
    end
endmodule : tb_tcmwac_top

// [test/tcmwac_core_model.sv]
`timescale 1ns/10ps
// Core side issuing system register accesses
module tcmwac_core_model (
    // Clock
    input  wire logic        mclk_i,
    // Request
    output logic             cp_valid_o,
    output logic             cp_write_o,
    output logic [2:0]       opc2_o,
    output logic [31:0]      cp_wdata_o,
    output logic             cp_secure_o,
    output logic             cp_privileged_o,
    // Answer
    input  wire logic [31:0] cp_rdata_i,
    input  wire logic        cp_hit_i,
    input  wire logic        cp_undef_i
);
    // Idle request at time zero
    initial {cp_valid_o, cp_write_o, opc2_o, cp_wdata_o, cp_secure_o,
        cp_privileged_o} = '0;
    // one access; region register left alone
    task automatic access(input logic w, input logic [2:0] o2,
        input logic [31:0] wd, input logic [1:0] mode,
        output logic [31:0] rd, output logic hit, output logic und);
        @(posedge mclk_i);
        cp_valid_o <= 1'b1;
        cp_write_o <= w;
        opc2_o <= o2;
        cp_wdata_o <= wd;
        {cp_secure_o, cp_privileged_o} <= mode;
        @(posedge mclk_i);
        cp_valid_o <= 1'b0;
        cp_wdata_o <= ~wd; // Released data must not look valid
        #1;
        {rd, hit, und} = {cp_rdata_i, cp_hit_i, cp_undef_i};
    endtask : access
endmodule : tcmwac_core_model

// [test/tcmwac_top_sva.sv]
`timescale 1ns/10ps
// Port checks on the coprocessor port and the data-side outputs
module tcmwac_checker (
    // Request
    input wire logic        mclk_i,
    input wire logic        reset_i,
    input wire logic        cp_valid_i,
    input wire logic        cp_write_i,
    input wire logic [3:0]  primary_reg_field_i,
    input wire logic [3:0]  secondary_reg_field_i,
    input wire logic [2:0]  opc1_i,
    input wire logic [2:0]  opc2_i,
    input wire logic        cp_secure_i,
    input wire logic        cp_privileged_i,
    input wire logic        secure_coproc_write_lock_i,
    // Answer
    input wire logic [31:0] cp_rdata_o,
    input wire logic        cp_hit_o,
    input wire logic        cp_undef_o,
    // Data-side check
    input wire logic        d_secure_i,
    input wire logic        d_page_ns_i,
    input wire logic        d_visible_o,
    input wire logic        d_ns_data_o,
    input wire logic        d_region_ok_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    // Decoded access, secure privileged mode and locked write
    logic req, sp, lk;
    assign req = cp_valid_i && primary_reg_field_i == 4'h9
        && secondary_reg_field_i == 4'h1 && opc1_i == 3'h0
        && (opc2_i == 3'h2 || opc2_i == 3'h3);
    assign sp = cp_secure_i && cp_privileged_i;
    assign lk = req && cp_write_i && secure_coproc_write_lock_i;
    hit_decode_a: assert property (cp_hit_o == $past(req))
        else $error("hit does not follow decode");
    undef_mode_a: assert property (req && !sp |=> cp_undef_o)
        else $error("undef missing for mode");
    write_lock_a: assert property (lk |=> cp_undef_o)
        else $error("undef missing for locked write");
    good_access_a: assert property (req && sp && !lk |=> !cp_undef_o)
        else $error("undef on allowed access");
    undef_cause_a: assert property (cp_undef_o |-> $past(req))
        else $error("undef without access");
    upper_zero_a: assert property (cp_rdata_o[31:1] == 31'h0)
        else $error("upper read bits not zero");
    rdata_cause_a: assert property (cp_rdata_o != 32'h0 |->
        $past(req && sp && !cp_write_i)) else $error("read data leaked");
    secure_vis_a: assert property (d_secure_i |->
        d_visible_o == (d_ns_data_o == d_page_ns_i)) else $error("vis");
    open_vis_a: assert property (!d_secure_i |->
        d_visible_o == d_ns_data_o) else $error("non-secure vis");
    region_world_a: assert property (d_region_ok_o ==
        (d_secure_i || d_ns_data_o)) else $error("region access world");
    cover property (req && sp && cp_write_i);
    cover property (lk && sp);
    cover property (d_secure_i && d_page_ns_i && d_visible_o);
endmodule : tcmwac_checker
bind tcmwac_top tcmwac_checker tcmwac_checker_inst (.*);
